// File: rtl/dcf_fuse_bank.sv
`timescale 1ns/100ps
// What this block does
// - Programmed bit reads 0, erased bit reads 1.
// - Words mapped from F80000h, boot word first.
// - Only table access reaches 800000h-FFFFFFh space.
// - Boot codes 110/010 protect up to 000AFEh.
// - Boot codes 101/001 protect up to 0015FEh.
// - Code 111 no boot segment; others reserved.
// - Boot write-protect bit 0 blocks boot writes.
// - General code-protect bit 0 enables security.
// - General write-protect bit 0 blocks writes.
// - Bit 7 of oscillator select enables two-speed.
// - Three-bit start-up oscillator source decode.
// - Clock switch and fail-safe monitor decode.
// - Secondary oscillator high or low power.
// - Primary frequency range declaration decode.
// - Clock output only when primary off or external.
// - Primary oscillator mode decode.
// - Watchdog word bit layout.
// - Unimplemented bits always read zero.
// - Watchdog fuse forces on, else software bit.
// - Window disable selects standard or windowed.
// - Prescaler select 1:128 or 1:32.
// - Postscaler ratio is two to the code.
module dcf_fuse_bank (
  // Clock, reset and clock enable.
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  // Nonvolatile storage read port.
  output logic [2:0]               nvm_index,
  input  wire logic [7:0]          nvm_data,
  // Nonvolatile storage program port.
  output logic                     nvm_write,
  output logic [7:0]               nvm_wdata,
  // Table access port.
  input  wire logic                table_read,
  input  wire logic                table_write,
  input  wire logic [23:0]         table_addr,
  input  wire logic [7:0]          table_wdata,
  output logic [7:0]               table_rdata,
  output logic                     table_error,
  // Software watchdog enable.
  input  wire logic                sw_watchdog_enable,
  // Program flash write target checks.
  input  wire logic [23:0]         flash_addr,
  output logic                     flash_write_allowed,
  // Load status.
  output logic                     config_valid,
  // Decoded protection controls.
  output logic                     boot_segment_present,
  output logic                     boot_high_security,
  output logic [23:0]              boot_end_addr,
  output logic                     boot_level_reserved,
  output logic                     boot_write_protect,
  output logic                     general_code_protect,
  output logic                     general_write_protect,
  // Decoded oscillator controls.
  output logic                     two_speed_startup_enable,
  output dcf_pkg::dcf_osc_src_t    startup_osc_select,
  output logic                     clock_switch_enable,
  output logic                     fail_safe_monitor_enable,
  output logic                     secondary_osc_high_power,
  output logic [1:0]               primary_freq_range,
  output logic                     primary_freq_reserved,
  output logic                     clock_output,
  output logic                     primary_osc_enable,
  output logic                     high_speed_crystal_mode,
  output logic                     standard_crystal_mode,
  output logic                     external_clock_mode,
  // Decoded watchdog controls.
  output logic                     watchdog_run,
  output logic                     watchdog_windowed,
  output logic [7:0]               watchdog_prescale,
  output logic [15:0]              watchdog_postscale
);

  // Per-word implemented-bit masks, indexed by word number.
  localparam logic [7:0] MASKS [dcf_pkg::NUM_WORDS] = '{
    dcf_pkg::MASK_BOOT, dcf_pkg::MASK_GENERAL, dcf_pkg::MASK_OSC_SEL, dcf_pkg::MASK_OSC,
    dcf_pkg::MASK_WATCHDOG, dcf_pkg::MASK_RESET, dcf_pkg::MASK_DEBUGGER,
    dcf_pkg::MASK_DEEPSLEEP
  };

  // Whole state of the block.
  typedef struct packed {
    dcf_pkg::dcf_state_t                   state;
    logic [2:0]                            index;
    logic [dcf_pkg::NUM_WORDS-1:0][7:0]    words;
    logic [7:0]                            rdata;
    logic                                  error;
    logic                                  wr;
    logic [7:0]                            wdata;
    logic [7:0]                            gen_cleared;
  } dcf_state_bundle_t;

  dcf_state_bundle_t state_reg;
  dcf_state_bundle_t state_next;

  logic       hit;
  logic [2:0] hit_idx;
  logic       in_cfg_space;
  logic [7:0] boot_w;
  logic [7:0] gen_w;
  logic [7:0] osel_w;
  logic [7:0] osc_w;
  logic [7:0] wdt_w;
  logic [2:0] boot_protect_level;
  logic [1:0] posc_mode;
  logic       in_boot;

  // Address decode against the eight word addresses.
  always_comb begin
    hit     = 1'b1;
    hit_idx = dcf_pkg::IDX_BOOT;
    unique case (table_addr)
      dcf_pkg::ADDR_BOOT:      hit_idx = dcf_pkg::IDX_BOOT;
      dcf_pkg::ADDR_GENERAL:   hit_idx = dcf_pkg::IDX_GENERAL;
      dcf_pkg::ADDR_OSC_SEL:   hit_idx = dcf_pkg::IDX_OSC_SEL;
      dcf_pkg::ADDR_OSC:       hit_idx = dcf_pkg::IDX_OSC;
      dcf_pkg::ADDR_WATCHDOG:  hit_idx = dcf_pkg::IDX_WATCHDOG;
      dcf_pkg::ADDR_RESET:     hit_idx = dcf_pkg::IDX_RESET;
      dcf_pkg::ADDR_DEBUGGER:  hit_idx = dcf_pkg::IDX_DEBUGGER;
      dcf_pkg::ADDR_DEEPSLEEP: hit_idx = dcf_pkg::IDX_DEEPSLEEP;
      default:                 hit     = 1'b0;
    endcase
  end

  // The table port is the only way in, and only for configuration space.
  assign in_cfg_space = (table_addr >= dcf_pkg::CFG_SPACE_LO) &&
                        (table_addr <= dcf_pkg::CFG_SPACE_HI);

  // Loader and table access; state only moves while the clock enable is high.
  always_comb begin
    state_next       = state_reg;
    state_next.wr    = 1'b0;
    state_next.error = 1'b0;
    unique case (state_reg.state)
      dcf_pkg::ST_LOAD: begin
        // Walk every word from storage before any decoded control counts.
        state_next.words[state_reg.index] = nvm_data & MASKS[state_reg.index];
        state_next.index = state_reg.index + 3'h1;
        if (state_reg.index == 3'(dcf_pkg::NUM_WORDS - 1)) begin
          state_next.state = dcf_pkg::ST_RUN;
        end
      end
      dcf_pkg::ST_RUN: begin
        if (table_read) begin
          if (in_cfg_space && hit) begin
            state_next.rdata = state_reg.words[hit_idx];
          end else begin
            state_next.rdata = 8'h00;
            state_next.error = 1'b1;
          end
        end else if (table_write) begin
          if (in_cfg_space && hit) begin
            state_next.wr    = 1'b1;
            state_next.index = hit_idx;
            state_next.state = dcf_pkg::ST_WAIT;
            if (hit_idx == dcf_pkg::IDX_GENERAL) begin
              // Protection may be tightened but never loosened in place. The latched
              // image is frozen until reset, so bits cleared since then are remembered.
              state_next.wdata = table_wdata & state_reg.words[hit_idx] &
                                 ~state_reg.gen_cleared & MASKS[hit_idx];
              state_next.gen_cleared = state_reg.gen_cleared |
                                       (MASKS[hit_idx] & ~state_next.wdata);
            end else begin
              state_next.wdata = table_wdata & MASKS[hit_idx];
            end
          end else begin
            state_next.error = 1'b1;
          end
        end
      end
      dcf_pkg::ST_WAIT: begin
        // Writes reach storage only; latches keep the reset-time image.
        state_next.state = dcf_pkg::ST_RUN;
      end
    endcase
  end

  // Single state register with asynchronous reset to the erased image.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.state <= dcf_pkg::ST_LOAD;
      state_reg.index <= 3'h0;
      state_reg.words <= '{default: dcf_pkg::ERASED_WORD};
      state_reg.rdata <= 8'h00;
      state_reg.error <= 1'b0;
      state_reg.wr    <= 1'b0;
      state_reg.wdata <= 8'h00;
      state_reg.gen_cleared <= 8'h00;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Storage ports and table answers.
  assign nvm_index    = state_reg.index;
  assign nvm_write    = state_reg.wr;
  assign nvm_wdata    = state_reg.wdata;
  assign table_rdata  = state_reg.rdata;
  assign table_error  = state_reg.error;
  assign config_valid = (state_reg.state != dcf_pkg::ST_LOAD);

  // Word views; all decode below treats 1 as the erased default.
  assign boot_w    = state_reg.words[dcf_pkg::IDX_BOOT];
  assign gen_w     = state_reg.words[dcf_pkg::IDX_GENERAL];
  assign osel_w    = state_reg.words[dcf_pkg::IDX_OSC_SEL];
  assign osc_w     = state_reg.words[dcf_pkg::IDX_OSC];
  assign wdt_w     = state_reg.words[dcf_pkg::IDX_WATCHDOG];
  assign boot_protect_level       = boot_w[dcf_pkg::BOOT_LVL_LSB +: 3];
  assign posc_mode = osc_w[dcf_pkg::OSC_MODE_LSB +: 2];

  // Boot segment size and security level.
  always_comb begin
    boot_segment_present = 1'b1;
    boot_high_security   = 1'b0;
    boot_end_addr        = 24'h000000;
    boot_level_reserved  = 1'b0;
    unique case (boot_protect_level)
      dcf_pkg::BSS_NONE:       boot_segment_present = 1'b0;
      dcf_pkg::BSS_SMALL_STD:  boot_end_addr = dcf_pkg::BOOT_END_SMALL;
      dcf_pkg::BSS_SMALL_HIGH: begin
        boot_end_addr      = dcf_pkg::BOOT_END_SMALL;
        boot_high_security = 1'b1;
      end
      dcf_pkg::BSS_LARGE_STD:  boot_end_addr = dcf_pkg::BOOT_END_LARGE;
      dcf_pkg::BSS_LARGE_HIGH: begin
        boot_end_addr      = dcf_pkg::BOOT_END_LARGE;
        boot_high_security = 1'b1;
      end
      default: begin
        // Reserved codes: treated as no segment so nothing is locked by accident.
        boot_segment_present = 1'b0;
        boot_level_reserved  = 1'b1;
      end
    endcase
  end

  // Write permission for a flash target address.
  assign boot_write_protect    = ~boot_w[dcf_pkg::BOOT_WRP_BIT];
  assign general_code_protect  = ~gen_w[dcf_pkg::GEN_CP_BIT];
  assign general_write_protect = ~gen_w[dcf_pkg::GEN_WRP_BIT];
  assign in_boot = boot_segment_present && (flash_addr >= dcf_pkg::BOOT_START) &&
                   (flash_addr <= boot_end_addr);
  assign flash_write_allowed = config_valid &&
                               (in_boot ? !boot_write_protect : !general_write_protect);

  // Oscillator selection decode.
  assign two_speed_startup_enable = osel_w[dcf_pkg::OSEL_TWO_SPEED_STARTUP_ENABLE_BIT];
  assign startup_osc_select = dcf_pkg::dcf_osc_src_t'(
                                8'h01 << osel_w[dcf_pkg::OSEL_SRC_LSB +: 3]);

  // Oscillator configuration decode.
  assign clock_switch_enable      = ~osc_w[dcf_pkg::OSC_CKSM_LSB + 1];
  assign fail_safe_monitor_enable = ~osc_w[dcf_pkg::OSC_CKSM_LSB + 1] &
                                    ~osc_w[dcf_pkg::OSC_CKSM_LSB];
  assign secondary_osc_high_power = osc_w[dcf_pkg::OSC_SECONDARY_OSCILLATOR_BIT];
  assign primary_freq_range       = osc_w[dcf_pkg::OSC_FREQ_LSB +: 2];
  assign primary_freq_reserved    = (primary_freq_range == 2'h0);
  assign primary_osc_enable       = (posc_mode != dcf_pkg::POSC_OFF);
  assign high_speed_crystal_mode  = (posc_mode == 2'h2);
  assign standard_crystal_mode    = (posc_mode == 2'h1);
  assign external_clock_mode      = (posc_mode == dcf_pkg::POSC_EXT);
  // The output pin is shared with the crystal, so a running crystal keeps it.
  assign clock_output = osc_w[dcf_pkg::OSC_CLOCK_OUTPUT_BIT] &&
                        ((posc_mode == dcf_pkg::POSC_OFF) ||
                         (posc_mode == dcf_pkg::POSC_EXT));

  // Watchdog decode.
  assign watchdog_run       = wdt_w[dcf_pkg::WDT_EN_BIT] | sw_watchdog_enable;
  assign watchdog_windowed  = ~wdt_w[dcf_pkg::WDT_WIN_BIT];
  assign watchdog_prescale  = wdt_w[dcf_pkg::WDT_PRE_BIT] ? dcf_pkg::WDT_PRE_LONG :
                              dcf_pkg::WDT_PRE_SHORT;
  assign watchdog_postscale = 16'h0001 << wdt_w[dcf_pkg::WDT_POST_LSB +: 4];

endmodule

// File: rtl/dcf_pkg.sv
package dcf_pkg;

  // Configuration space and word addresses (byte addresses, 24-bit program space).
  localparam logic [23:0] CFG_SPACE_LO   = 24'h800000;
  localparam logic [23:0] CFG_SPACE_HI   = 24'hffffff;
  localparam logic [23:0] CFG_BASE       = 24'hf80000;
  localparam logic [23:0] ADDR_BOOT      = 24'hf80000;
  localparam logic [23:0] ADDR_GENERAL   = 24'hf80004;
  localparam logic [23:0] ADDR_OSC_SEL   = 24'hf80006;
  localparam logic [23:0] ADDR_OSC       = 24'hf80008;
  localparam logic [23:0] ADDR_WATCHDOG  = 24'hf8000a;
  localparam logic [23:0] ADDR_RESET     = 24'hf8000c;
  localparam logic [23:0] ADDR_DEBUGGER  = 24'hf8000e;
  localparam logic [23:0] ADDR_DEEPSLEEP = 24'hf80010;

  // Number of configuration words and their indices in the bank.
  localparam int          NUM_WORDS      = 8;
  localparam logic [2:0]  IDX_BOOT       = 3'h0;
  localparam logic [2:0]  IDX_GENERAL    = 3'h1;
  localparam logic [2:0]  IDX_OSC_SEL    = 3'h2;
  localparam logic [2:0]  IDX_OSC        = 3'h3;
  localparam logic [2:0]  IDX_WATCHDOG   = 3'h4;
  localparam logic [2:0]  IDX_RESET      = 3'h5;
  localparam logic [2:0]  IDX_DEBUGGER   = 3'h6;
  localparam logic [2:0]  IDX_DEEPSLEEP  = 3'h7;

  // Implemented-bit masks; unimplemented positions read as zero.
  localparam logic [7:0]  MASK_BOOT      = 8'h0f;
  localparam logic [7:0]  MASK_GENERAL   = 8'h03;
  localparam logic [7:0]  MASK_OSC_SEL   = 8'h87;
  localparam logic [7:0]  MASK_OSC       = 8'hff;
  localparam logic [7:0]  MASK_WATCHDOG  = 8'hdf;
  localparam logic [7:0]  MASK_RESET     = 8'hfb;
  localparam logic [7:0]  MASK_DEBUGGER  = 8'h83;
  localparam logic [7:0]  MASK_DEEPSLEEP = 8'hff;

  // Erased (unprogrammed) value of every cell.
  localparam logic [7:0]  ERASED_WORD    = 8'hff;

  // Boot word fields.
  localparam int          BOOT_WRP_BIT   = 0;
  localparam int          BOOT_LVL_LSB   = 1;
  localparam logic [2:0]  BSS_NONE       = 3'h7;
  localparam logic [2:0]  BSS_SMALL_STD  = 3'h6;
  localparam logic [2:0]  BSS_SMALL_HIGH = 3'h2;
  localparam logic [2:0]  BSS_LARGE_STD  = 3'h5;
  localparam logic [2:0]  BSS_LARGE_HIGH = 3'h1;
  localparam logic [23:0] BOOT_START     = 24'h000200;
  localparam logic [23:0] BOOT_END_SMALL = 24'h000afe;
  localparam logic [23:0] BOOT_END_LARGE = 24'h0015fe;

  // General segment fields.
  localparam int          GEN_WRP_BIT    = 0;
  localparam int          GEN_CP_BIT     = 1;

  // Oscillator selection fields.
  localparam int          OSEL_TWO_SPEED_STARTUP_ENABLE_BIT  = 7;
  localparam int          OSEL_SRC_LSB   = 0;

  // Oscillator configuration fields.
  localparam int          OSC_CKSM_LSB   = 6;
  localparam int          OSC_SECONDARY_OSCILLATOR_BIT   = 5;
  localparam int          OSC_FREQ_LSB   = 3;
  localparam int          OSC_CLOCK_OUTPUT_BIT   = 2;
  localparam int          OSC_MODE_LSB   = 0;
  localparam logic [1:0]  POSC_OFF       = 2'h3;
  localparam logic [1:0]  POSC_EXT       = 2'h0;

  // Watchdog fields.
  localparam int          WDT_EN_BIT     = 7;
  localparam int          WDT_WIN_BIT    = 6;
  localparam int          WDT_PRE_BIT    = 4;
  localparam int          WDT_POST_LSB   = 0;
  localparam logic [7:0]  WDT_PRE_LONG   = 8'h80;
  localparam logic [7:0]  WDT_PRE_SHORT  = 8'h20;

  // One-hot start-up oscillator selections.
  typedef enum logic [7:0] {
    OSC_FAST_RC        = 8'h01,
    OSC_FAST_RC_PLL    = 8'h02,
    OSC_PRIMARY        = 8'h04,
    OSC_PRIMARY_PLL    = 8'h08,
    OSC_SECONDARY      = 8'h10,
    OSC_LOW_POWER_RC   = 8'h20,
    OSC_LP_FAST_RC_DIV = 8'h40,
    OSC_FAST_RC_DIV    = 8'h80
  } dcf_osc_src_t;

  // One-hot loader states.
  typedef enum logic [2:0] {
    ST_LOAD = 3'h1,
    ST_RUN  = 3'h2,
    ST_WAIT = 3'h4
  } dcf_state_t;

endpackage

// File: dv/dcf_fuse_bank_asserts.sv
`timescale 1ns/100ps
module dcf_fuse_bank_asserts (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset_n,
  // Table access and storage port.
  input wire logic        clk_en,
  input wire logic        table_read,
  input wire logic        table_write,
  input wire logic [23:0] table_addr,
  input wire logic [7:0]  table_wdata,
  input wire logic [7:0]  table_rdata,
  input wire logic        table_error,
  input wire logic [2:0]  nvm_index,
  input wire logic        nvm_write,
  input wire logic [7:0]  nvm_wdata,
  input wire logic        config_valid,
  // Decoded controls.
  input wire logic        sw_watchdog_enable,
  input wire logic        watchdog_run,
  input wire logic        boot_segment_present,
  input wire logic [23:0] boot_end_addr,
  input wire logic        clock_output,
  input wire logic        primary_osc_enable,
  input wire logic        external_clock_mode,
  input wire logic        clock_switch_enable,
  input wire logic        fail_safe_monitor_enable,
  input wire logic [7:0]  watchdog_prescale,
  input wire logic [15:0] watchdog_postscale
);
  // Everything here lives in the one system clock domain.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // A program strobe is a single pulse and only ever answers a taken table write.
  a_write_one_cycle: assert property (nvm_write |=> !nvm_write)
    else $error("program strobe lasted more than one cycle");
  a_write_needs_req: assert property (nvm_write |->
      $past(table_write && !table_read && clk_en && config_valid))
    else $error("program strobe without a taken table write");
  // Addresses below the configuration space are refused with an error pulse.
  a_bad_read_error: assert property ((table_read && clk_en && config_valid && !nvm_write
      && table_addr < 24'h800000) |=> (table_error && table_rdata == 8'h00))
    else $error("read outside configuration space not refused");
  a_bad_write_drop: assert property ((table_write && !table_read && clk_en && config_valid
      && !nvm_write && table_addr < 24'h800000) |=> (table_error && !nvm_write))
    else $error("write outside configuration space not refused");
  // Stored general-word data may never carry a bit that the write itself cleared.
  a_general_clear_only: assert property ((nvm_write && nvm_index == 3'h1) |->
      (nvm_wdata & ~$past(table_wdata)) == 8'h00)
    else $error("general word write set a cleared bit");
  a_boot_upper_zero: assert property ((nvm_write && nvm_index == 3'h0) |->
      nvm_wdata[7:4] == 4'h0)
    else $error("boot word write carried unimplemented bits");
  a_rdata_holds: assert property (!(table_read && clk_en) |=> $stable(table_rdata))
    else $error("read data changed without a read");
  a_valid_sticks: assert property (config_valid |=> config_valid)
    else $error("load status dropped without reset");
  a_decode_stable: assert property ((config_valid && $past(config_valid)) |->
      $stable({boot_end_addr, watchdog_prescale, watchdog_postscale, clock_output}))
    else $error("decoded controls changed after load");
  a_clkout_gate: assert property (clock_output |->
      (!primary_osc_enable || external_clock_mode))
    else $error("clock output with crystal primary mode");
  a_monitor_switch: assert property (fail_safe_monitor_enable |-> clock_switch_enable)
    else $error("monitor enabled without clock switching");
  a_wdt_software: assert property ((config_valid && sw_watchdog_enable) |-> watchdog_run)
    else $error("software watchdog enable ignored");
  a_boot_end_range: assert property (boot_segment_present |->
      (boot_end_addr == 24'h000afe || boot_end_addr == 24'h0015fe))
    else $error("boot segment end address out of set");
endmodule

// File: dv/test_dcf_fuse_bank.sv
`timescale 1ns/100ps
module test_dcf_fuse_bank;
  localparam logic [7:0] MSK [8] = '{8'h0f, 8'h03, 8'h87, 8'hff, 8'hdf, 8'hfb, 8'h83, 8'hff};
  logic clk, reset_n, clk_en, table_read, table_write, sw_watchdog_enable, nvm_write;
  logic table_error, flash_write_allowed, config_valid, boot_segment_present;
  logic boot_high_security, boot_level_reserved, boot_write_protect, general_code_protect;
  logic general_write_protect, two_speed_startup_enable, clock_switch_enable;
  logic fail_safe_monitor_enable, secondary_osc_high_power, primary_freq_reserved;
  logic clock_output, primary_osc_enable, high_speed_crystal_mode, standard_crystal_mode;
  logic external_clock_mode, watchdog_run, watchdog_windowed;
  logic [1:0]  primary_freq_range;
  logic [2:0]  nvm_index, c;
  logic [7:0]  nvm_data, nvm_wdata, table_wdata, table_rdata, watchdog_prescale;
  logic [7:0]  mem [8];
  logic [15:0] watchdog_postscale;
  logic [23:0] table_addr, flash_addr, boot_end_addr;
  dcf_pkg::dcf_osc_src_t startup_osc_select;
  int err_count, compares, cyc;

  dcf_fuse_bank u_dcf_fuse_bank (.clk, .reset_n, .clk_en, .nvm_index, .nvm_data, .nvm_write,
    .nvm_wdata, .table_read, .table_write, .table_addr, .table_wdata, .table_rdata,
    .table_error, .sw_watchdog_enable, .flash_addr, .flash_write_allowed, .config_valid,
    .boot_segment_present, .boot_high_security, .boot_end_addr, .boot_level_reserved,
    .boot_write_protect, .general_code_protect, .general_write_protect,
    .two_speed_startup_enable, .startup_osc_select, .clock_switch_enable,
    .fail_safe_monitor_enable, .secondary_osc_high_power, .primary_freq_range,
    .primary_freq_reserved, .clock_output, .primary_osc_enable, .high_speed_crystal_mode,
    .standard_crystal_mode, .external_clock_mode, .watchdog_run, .watchdog_windowed,
    .watchdog_prescale, .watchdog_postscale);

  // Storage cells answer by index at once and take the byte on each program strobe.
  assign nvm_data = mem[nvm_index];
  always @(posedge clk) begin
    if (nvm_write) begin
      mem[nvm_index] <= nvm_wdata;
    end
  end

  // Clock and a hang guard well beyond the few hundred cycles the tests need.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [23:0] adr(int k);
    return (k == 0) ? 24'hf80000 : 24'hf80002 + 24'(2 * k);
  endfunction

  // Reset, then hold the clock enable low to prove the loader freezes.
  task automatic boot();
    @(negedge clk);
    reset_n = 1'b0;
    clk_en = 1'b0;
    table_read = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("config_valid", 0, config_valid);
    clk_en = 1'b1;
    repeat (7) @(negedge clk);
    chk("config_valid", 0, config_valid);
    @(negedge clk);
    chk("config_valid", 1, config_valid);
  endtask

  task automatic rd(logic [23:0] a, logic [7:0] exp, logic err);
    table_read = 1'b1;
    table_write = 1'b0;
    table_addr = a;
    @(negedge clk);
    chk("table_rdata", exp, table_rdata);
    chk("table_error", err, table_error);
  endtask

  // One idle cycle must follow every write, so the task waits it out itself.
  task automatic wr(logic [2:0] k, logic [23:0] a, logic [7:0] d, logic [7:0] exp, logic err);
    table_read = 1'b0;
    table_write = 1'b1;
    table_addr = a;
    table_wdata = d;
    @(negedge clk);
    table_write = 1'b0;
    chk("nvm_write", !err, nvm_write);
    chk("table_error", err, table_error);
    if (!err) begin
      chk("nvm_index", k, nvm_index);
      chk("nvm_wdata", exp, nvm_wdata);
    end
    repeat (2) @(negedge clk);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    {clk, reset_n, clk_en, table_read, table_write, sw_watchdog_enable} = '0;
    {table_addr, table_wdata, flash_addr, err_count, compares, cyc} = '0;
    // Each code drives every field at once; code 7 is the fully erased image.
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      mem = '{8{8'hff}};
      mem[0] = {4'hf, c, c[0]};
      mem[1] = {6'h3f, c[2:1]};
      mem[2] = {c[1], 4'hf, c};
      mem[3] = {c[2:1], c[0], c[1:0], c[2], c[1:0]};
      mem[4] = {c[0], c[1], 1'b1, c[2], c, c[0]};
      sw_watchdog_enable = 1'b0;
      flash_addr = 24'h000400;
      boot();
      for (int k = 0; k < 8; k++) rd(adr(k), mem[k] & MSK[k], 0);
      chk("present", c inside {3'h6, 3'h5, 3'h2, 3'h1}, boot_segment_present);
      chk("high_sec", c == 3'h2 || c == 3'h1, boot_high_security);
      chk("reserved", c inside {3'h0, 3'h3, 3'h4}, boot_level_reserved);
      if (boot_segment_present === 1'b1) chk("end", c[1] ? 24'h000afe : 24'h0015fe, boot_end_addr);
      chk("boot_wp", !c[0], boot_write_protect);
      chk("gen_cp", !c[2], general_code_protect);
      chk("gen_wp", !c[1], general_write_protect);
      chk("flash_ok", c inside {3'h6, 3'h5, 3'h2, 3'h1} ? c[0] : c[1], flash_write_allowed);
      chk("two_speed", c[1], two_speed_startup_enable);
      chk("osc_src", 8'h01 << c, startup_osc_select);
      chk("switch", !c[2], clock_switch_enable);
      chk("monitor", c[2:1] == 2'h0, fail_safe_monitor_enable);
      chk("secondary_oscillator_hp", c[0], secondary_osc_high_power);
      chk("freq", c[1:0], primary_freq_range);
      chk("freq_rsv", c[1:0] == 2'h0, primary_freq_reserved);
      chk("clkout", c[2] && (c[1:0] == 2'h3 || c[1:0] == 2'h0), clock_output);
      chk("posc_on", c[1:0] != 2'h3, primary_osc_enable);
      chk("hs", c[1:0] == 2'h2, high_speed_crystal_mode);
      chk("xt", c[1:0] == 2'h1, standard_crystal_mode);
      chk("ec", c[1:0] == 2'h0, external_clock_mode);
      chk("wdt_run", c[0], watchdog_run);
      chk("windowed", !c[1], watchdog_windowed);
      chk("prescale", c[2] ? 8'h80 : 8'h20, watchdog_prescale);
      chk("postscale", 16'h1 << {c, c[0]}, watchdog_postscale);
      sw_watchdog_enable = 1'b1;
      flash_addr = 24'h002000;
      @(negedge clk);
      chk("wdt_sw", 1, watchdog_run);
      chk("flash_gen", c[1], flash_write_allowed);
      $display("decode test for code %0d done", i);
    end
    // Refusals, masked writes and clear-only general bits on the erased image.
    rd(24'h7fffff, 8'h00, 1);
    rd(24'hf80002, 8'h00, 1);
    wr(3'h0, 24'h7ffffe, 8'h00, 8'h00, 1);
    wr(3'h0, 24'hf80000, 8'hf4, 8'h04, 0);
    wr(3'h4, 24'hf8000a, 8'hff, 8'hdf, 0);
    wr(3'h1, 24'hf80004, 8'hfe, 8'h02, 0);
    // A second write before reset must not set the bit cleared by the first.
    wr(3'h1, 24'hf80004, 8'hfd, 8'h00, 0);
    chk("stable", 0, boot_segment_present);
    boot();
    rd(24'hf80000, 8'h04, 0);
    rd(24'hf80004, 8'h00, 0);
    chk("high_sec", 1, boot_high_security);
    chk("gen_wp", 1, general_write_protect);
    chk("gen_cp", 1, general_code_protect);
    wr(3'h1, 24'hf80004, 8'hff, 8'h00, 0);
    $display("access test done");
    conclude();
  end
endmodule

bind dcf_fuse_bank dcf_fuse_bank_asserts u_dcf_fuse_bank_asserts (.clk, .reset_n, .clk_en,
  .table_read, .table_write, .table_addr, .table_wdata, .table_rdata, .table_error,
  .nvm_index, .nvm_write, .nvm_wdata, .config_valid, .sw_watchdog_enable, .watchdog_run,
  .boot_segment_present, .boot_end_addr, .clock_output, .primary_osc_enable,
  .external_clock_mode, .clock_switch_enable, .fail_safe_monitor_enable,
  .watchdog_prescale, .watchdog_postscale);
